//--- bench/atpg_fmt_sink.sv
`timescale 1ns/100ps
module atpg_fmt_sink (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    // formatted stream in
    input wire out_valid,
    // observation
    output reg [15:0] sample_count
);
    // one word taken per valid beat
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sample_count <= 16'h0000;
        end else if (out_valid) begin
            sample_count <= sample_count + 16'h0001;
        end
    end
endmodule // atpg_fmt_sink

//--- bench/atpg_top_props.sv
`timescale 1ns/100ps
module atpg_top_chk (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // register port
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata,
    // stream
    input wire sample_valid,
    input wire [13:0] adc_a_data,
    input wire [13:0] adc_b_data,
    input wire out_valid,
    input wire [13:0] out_a_data,
    input wire [13:0] out_b_data,
    input wire out_test_active,
    input wire out_fmt_bypass,
    input wire [3:0] ddc_test_q_en
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    wire mode_wr = ce && reg_wr && reg_addr == 12'h550;
    wire [3:0] wm = reg_wdata[3:0];

    valid_delay_a: assert property (ce |=> out_valid == $past(sample_valid))
        else $error("out_valid not one cycle after slot");
    hold_slots_a: assert property (ce && !sample_valid |=> $stable(out_a_data))
        else $error("data moved without a slot");
    ce_freeze_a: assert property (!ce |=> $stable({out_valid, out_a_data, out_b_data}))
        else $error("outputs moved while stopped");
    off_idle_a: assert property (mode_wr && wm == 4'h0 |-> ##2 !out_test_active)
        else $error("test active after mode off");
    reserved_idle_a: assert property (mode_wr && wm > 4'h8 && wm < 4'hf
        |-> ##2 !out_test_active)
        else $error("reserved mode gave test data");
    listed_on_a: assert property (mode_wr && wm != 4'h0 && (wm < 4'h9 || wm == 4'hf)
        |-> ##2 out_test_active)
        else $error("listed mode not active");
    adc_passthru_a: assert property (ce && sample_valid |=> out_test_active ||
        (out_a_data == $past(adc_a_data) && out_b_data == $past(adc_b_data)))
        else $error("converter data not passed");
    bypass_active_a: assert property (out_fmt_bypass |-> out_test_active)
        else $error("bypass without test pattern");
    q3_none_a: assert property (ddc_test_q_en[3] == 1'b0)
        else $error("fourth quadrature got test data");
    rdata_idle_a: assert property (ce && !reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
endmodule // atpg_top_chk

bind atpg_top atpg_top_chk u_chk (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sample_valid(sample_valid), .adc_a_data(adc_a_data),
    .adc_b_data(adc_b_data), .out_valid(out_valid), .out_a_data(out_a_data),
    .out_b_data(out_b_data), .out_test_active(out_test_active),
    .out_fmt_bypass(out_fmt_bypass), .ddc_test_q_en(ddc_test_q_en));

//--- bench/tb_atpg_top.sv
`timescale 1ns/100ps
module tb_atpg_top;
    reg clk_sys, resetn, ce, reg_wr, reg_rd, sample_valid;
    reg [11:0] reg_addr;
    reg [7:0] reg_wdata, rd_val;
    reg [13:0] adc_a_data, adc_b_data;
    reg [3:0] m;
    wire [7:0] reg_rdata;
    wire out_valid, out_test_active, out_fmt_bypass;
    wire [13:0] out_a_data, out_b_data, ddc_test_i_data, ddc_test_q_data;
    wire [3:0] ddc_test_i_en, ddc_test_q_en;
    wire [15:0] sink_count;
    integer n_mismatch, total_checks, n_slots, cycles, i, k;

    atpg_top dut (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_valid(sample_valid), .adc_a_data(adc_a_data), .adc_b_data(adc_b_data),
        .out_valid(out_valid), .out_a_data(out_a_data), .out_b_data(out_b_data),
        .out_test_active(out_test_active), .out_fmt_bypass(out_fmt_bypass),
        .ddc_test_i_en(ddc_test_i_en), .ddc_test_q_en(ddc_test_q_en),
        .ddc_test_i_data(ddc_test_i_data), .ddc_test_q_data(ddc_test_q_data));
    atpg_fmt_sink sink (.clk_sys(clk_sys), .resetn(resetn), .out_valid(out_valid),
        .sample_count(sink_count));

    task check(input [63:0] what, input [13:0] seen, input [13:0] expv);
        begin
            total_checks = total_checks + 1;
            if (seen !== expv) begin
                n_mismatch = n_mismatch + 1;
                $display("[FAIL] %0s expected %h seen %h", what, expv, seen);
            end
        end
    endtask
    task test_done;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_mismatch);
            if (n_mismatch == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task wr(input [11:0] a, input [7:0] d);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk_sys);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [11:0] a);
        begin
            @(posedge clk_sys);
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk_sys);
            reg_rd <= 1'b0;
            #1;
            rd_val = reg_rdata;
        end
    endtask
    // mode write, then one cycle for the pattern restart
    task mode(input [7:0] d);
        begin
            wr(12'h550, d);
            @(posedge clk_sys);
        end
    endtask
    task slot(input [13:0] ea, input [13:0] eb, input act, input byp);
        begin
            @(posedge clk_sys);
            sample_valid <= 1'b1;
            @(posedge clk_sys);
            sample_valid <= 1'b0;
            #1;
            n_slots = n_slots + 1;
            check("valid", {13'h0, out_valid}, 14'h1);
            check("out_a", out_a_data, ea);
            check("out_b", out_b_data, eb);
            check("active", {13'h0, out_test_active}, {13'h0, act});
            check("bypass", {13'h0, out_fmt_bypass}, {13'h0, byp});
            check("ddc_i", ddc_test_i_data, act ? ea : 14'h0000);
            check("ddc_q", ddc_test_q_data, act ? eb : 14'h0000);
        end
    endtask
    function [13:0] pat(input [3:0] md, input integer n);
        case (md)
            4'h1: pat = 14'h0000;
            4'h2: pat = 14'h1fff;
            4'h3: pat = 14'h2000;
            4'h4: pat = n[0] ? 14'h2aaa : 14'h1555;
            4'h7: pat = n[0] ? 14'h3fff : 14'h0000;
            default: pat = n[13:0];
        endcase
    endfunction
    function [7:0] ub(input integer n);
        ub = 8'h3c + 8'h25 * n[7:0];
    endfunction
    function [13:0] uw(input integer n);
        reg [15:0] w;
        begin
            w = {ub(2 * n + 1), ub(2 * n)};
            uw = w[15:2];
        end
    endfunction

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        cycles = cycles + 1;
        if (cycles == 2000) begin
            n_mismatch = n_mismatch + 1;
            test_done;
        end
    end
    initial begin
        {resetn, reg_wr, reg_rd, sample_valid, reg_addr, reg_wdata} = 0;
        ce = 1'b1;
        adc_a_data = 14'h0abc;
        adc_b_data = 14'h1234;
        {n_mismatch, total_checks, n_slots, cycles} = 0;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(12'h550);
        check("mode", {6'h0, rd_val}, 14'h0000);
        rd(12'h100);
        check("unmap", {6'h0, rd_val}, 14'h0000);
        wr(12'h327, 8'h05);
        wr(12'h347, 8'h01);
        wr(12'h367, 8'h04);
        wr(12'h387, 8'h05);
        rd(12'h387);
        check("fourth_downconverter", {6'h0, rd_val}, 14'h0005);
        check("i_en", {10'h0, ddc_test_i_en}, 14'h000b);
        check("q_en", {10'h0, ddc_test_q_en}, 14'h0005);
        $display("test registers done");
        for (i = 0; i < 6; i = i + 1) begin
            m = (i == 5) ? 4'hf : (i == 4) ? 4'h7 : (i == 3) ? 4'h4 : i[3:0] + 4'h1;
            mode({4'h0, m});
            for (k = 0; k < 5; k = k + 1)
                slot(pat(m, k), pat(m, k), 1'b1, 1'b0);
        end
        $display("test fixed patterns done");
        for (i = 0; i < 2; i = i + 1) begin
            mode(8'h15);
            mode(8'h05);
            slot(14'h3fd7, 14'h3fd7, 1'b1, 1'b1);
            slot(14'h0002, 14'h0002, 1'b1, 1'b1);
            slot(14'h26e0, 14'h26e0, 1'b1, 1'b1);
        end
        mode(8'h26);
        mode(8'h06);
        slot(14'h125b, 14'h125b, 1'b1, 1'b1);
        slot(14'h3c9a, 14'h3c9a, 1'b1, 1'b1);
        slot(14'h2660, 14'h2660, 1'b1, 1'b1);
        $display("test sequences done");
        for (i = 0; i < 8; i = i + 1)
            wr(12'h551 + i[11:0], ub(i));
        mode(8'h08);
        for (k = 0; k < 6; k = k + 1)
            slot(uw(k % 4), uw(k % 4), 1'b1, 1'b1);
        mode(8'h88);
        for (k = 0; k < 6; k = k + 1)
            slot(k < 4 ? uw(k) : 14'h0000, k < 4 ? uw(k) : 14'h0000, 1'b1, 1'b1);
        rd(12'h55f);
        check("status", {6'h0, rd_val}, 14'h0007);
        $display("test user words done");
        mode(8'h09);
        slot(adc_a_data, adc_b_data, 1'b0, 1'b0);
        mode(8'h00);
        slot(adc_a_data, adc_b_data, 1'b0, 1'b0);
        mode(8'h04);
        slot(14'h1555, 14'h1555, 1'b1, 1'b0);
        @(posedge clk_sys);
        ce <= 1'b0;
        sample_valid <= 1'b1;
        @(posedge clk_sys);
        ce <= 1'b1;
        sample_valid <= 1'b0;
        #1;
        check("frozen", {13'h0, out_valid}, 14'h0000);
        slot(14'h2aaa, 14'h2aaa, 1'b1, 1'b0);
        @(posedge clk_sys);
        #1;
        check("count", sink_count[13:0], n_slots[13:0]);
        $display("test stop and reserved done");
        test_done;
    end
endmodule // tb_atpg_top

//--- verilog/atpg_map.vh
`ifndef ATPG_MAP_VH
`define ATPG_MAP_VH

// register bus
`define ATPG_ADDR_W 12
`define ATPG_DATA_W 8
`define ATPG_REG_RESET 8'h00

// register offsets
`define ATPG_OFS_DDC0 12'h327
`define ATPG_OFS_DDC1 12'h347
`define ATPG_OFS_DDC2 12'h367
`define ATPG_OFS_FOURTH_DOWNCONVERTER 12'h387
`define ATPG_OFS_MODE 12'h550
`define ATPG_OFS_UP_FIRST 12'h551
`define ATPG_OFS_UP_LAST 12'h558
`define ATPG_OFS_STATUS 12'h55f

// fields of the test mode control register
`define ATPG_F_MODE 3:0
`define ATPG_F_RST_LONG 4
`define ATPG_F_RST_SHORT 5
`define ATPG_F_SINGLE 7

// fields of the downconverter test enable registers
`define ATPG_F_DDC_I 0
`define ATPG_F_DDC_Q 2
`define ATPG_DDC_COUNT 4

// fields of the status register
`define ATPG_F_ST_ACTIVE 0
`define ATPG_F_ST_DONE 1
`define ATPG_F_ST_BYPASS 2

// mode codes
`define ATPG_MODE_OFF 4'h0
`define ATPG_MODE_MID 4'h1
`define ATPG_MODE_POS 4'h2
`define ATPG_MODE_NEG 4'h3
`define ATPG_MODE_CHK 4'h4
`define ATPG_MODE_PN_LONG 4'h5
`define ATPG_MODE_PN_SHORT 4'h6
`define ATPG_MODE_TOGGLE 4'h7
`define ATPG_MODE_USER 4'h8
`define ATPG_MODE_RAMP 4'hf

// sample codes
`define ATPG_SAMPLE_W 14
`define ATPG_CODE_MID 14'h0000
`define ATPG_CODE_POS 14'h1fff
`define ATPG_CODE_NEG 14'h2000
`define ATPG_CODE_CHK_A 14'h1555
`define ATPG_CODE_CHK_B 14'h2aaa
`define ATPG_CODE_ZERO 14'h0000
`define ATPG_CODE_ONES 14'h3fff
`define ATPG_RAMP_STEP 14'h0001

// pseudo-random generators
`define ATPG_PN_LONG_W 23
`define ATPG_PN_LONG_TAP 18
`define ATPG_PN_LONG_SEED 23'h003aff
`define ATPG_PN_SHORT_W 9
`define ATPG_PN_SHORT_TAP 5
`define ATPG_PN_SHORT_SEED 9'h092

// user words
`define ATPG_UP_COUNT 8
`define ATPG_UP_WORD_W 16
`define ATPG_UP_LSB 2

`endif

//--- verilog/atpg_prbs.v
`timescale 1ns/100ps
`include "atpg_map.vh"

// fibonacci lfsr x^W + x^TAP + 1, fourteen steps per sample slot
module atpg_prbs #(
    parameter W = `ATPG_PN_LONG_W,
    parameter TAP = `ATPG_PN_LONG_TAP,
    parameter [W-1:0] SEED = `ATPG_PN_LONG_SEED
) (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // control
    input wire advance,
    input wire restart,
    // sample
    output reg [`ATPG_SAMPLE_W-1:0] sample
);

    reg [W-1:0] state_reg;
    reg [W-1:0] state_next;
    reg fb;
    integer i;

    // shifts right: bit 0 leaves first into the sample msb, so the seed itself
    // opens the stream; the new top bit is bit 0 xor bit W-TAP
    always @* begin
        state_next = state_reg;
        sample = `ATPG_CODE_ZERO;
        fb = 1'b0;
        for (i = 0; i < `ATPG_SAMPLE_W; i = i + 1) begin
            sample[`ATPG_SAMPLE_W-1-i] = state_next[0];
            fb = state_next[0] ^ state_next[W-TAP];
            state_next = {fb, state_next[W-1:1]};
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_reg <= SEED;
        end else if (ce) begin
            if (restart) begin
                state_reg <= SEED;
            end else if (advance) begin
                state_reg <= state_next;
            end
        end
    end

endmodule // atpg_prbs

//--- verilog/atpg_top.v
`timescale 1ns/100ps
`include "atpg_map.vh"

module atpg_top (
    // clock, reset, clock enable
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // register port
    input wire [`ATPG_ADDR_W-1:0] reg_addr,
    input wire [`ATPG_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`ATPG_DATA_W-1:0] reg_rdata,
    // converter samples in
    input wire sample_valid,
    input wire [`ATPG_SAMPLE_W-1:0] adc_a_data,
    input wire [`ATPG_SAMPLE_W-1:0] adc_b_data,
    // to output formatting
    output reg out_valid,
    output reg [`ATPG_SAMPLE_W-1:0] out_a_data,
    output reg [`ATPG_SAMPLE_W-1:0] out_b_data,
    output reg out_test_active,
    output reg out_fmt_bypass,
    // digital_downconverter test injection
    output reg [3:0] ddc_test_i_en,
    output reg [3:0] ddc_test_q_en,
    output reg [`ATPG_SAMPLE_W-1:0] ddc_test_i_data,
    output reg [`ATPG_SAMPLE_W-1:0] ddc_test_q_data
);

    // registers
    reg [`ATPG_DATA_W-1:0] ddc0_test_enable_control_reg;
    reg [`ATPG_DATA_W-1:0] ddc1_test_enable_control_reg;
    reg [`ATPG_DATA_W-1:0] ddc2_test_enable_control_reg;
    reg [`ATPG_DATA_W-1:0] fourth_downconverter_test_enable_control_reg;
    reg [`ATPG_DATA_W-1:0] test_mode_control_reg;
    reg [`ATPG_DATA_W-1:0] user_pattern_reg [0:`ATPG_UP_COUNT-1];
    reg restart_reg;
    reg [`ATPG_DATA_W-1:0] rdata_next;

    // pattern state
    reg phase_reg;
    reg [`ATPG_SAMPLE_W-1:0] ramp_reg;
    reg [`ATPG_SAMPLE_W-1:0] pattern;
    reg active;
    reg bypass;

    wire [3:0] mode;
    wire [`ATPG_ADDR_W-1:0] up_off;
    wire up_hit;
    wire slot;
    wire [`ATPG_SAMPLE_W-1:0] pn_long_sample;
    wire [`ATPG_SAMPLE_W-1:0] pn_short_sample;
    wire [`ATPG_SAMPLE_W-1:0] user_sample;
    wire user_done;
    wire [4*`ATPG_UP_WORD_W-1:0] user_words;
    wire pn_long_step;
    wire pn_short_step;
    wire user_step;

    assign mode = test_mode_control_reg[`ATPG_F_MODE];
    assign up_off = reg_addr - `ATPG_OFS_UP_FIRST;
    assign up_hit = (reg_addr >= `ATPG_OFS_UP_FIRST) && (reg_addr <= `ATPG_OFS_UP_LAST);
    // generators step only on real sample slots of a running clock
    assign slot = sample_valid && active;
    // each generator steps only on slots of its own mode
    assign pn_long_step = slot && (mode == `ATPG_MODE_PN_LONG);
    assign pn_short_step = slot && (mode == `ATPG_MODE_PN_SHORT);
    assign user_step = slot && (mode == `ATPG_MODE_USER);

    // user words: even offset low byte, odd offset high byte
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_words
            assign user_words[g*`ATPG_UP_WORD_W +: `ATPG_UP_WORD_W] =
                {user_pattern_reg[2*g+1], user_pattern_reg[2*g]};
        end
    endgenerate

    // register writes
    integer k;
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ddc0_test_enable_control_reg <= `ATPG_REG_RESET;
            ddc1_test_enable_control_reg <= `ATPG_REG_RESET;
            ddc2_test_enable_control_reg <= `ATPG_REG_RESET;
            fourth_downconverter_test_enable_control_reg <= `ATPG_REG_RESET;
            test_mode_control_reg <= `ATPG_REG_RESET;
            restart_reg <= 1'b0;
            for (k = 0; k < `ATPG_UP_COUNT; k = k + 1) begin
                user_pattern_reg[k] <= `ATPG_REG_RESET;
            end
        end else if (ce) begin
            // one cycle late, so the new mode is in place when phase and ramp restart
            restart_reg <= reg_wr && (reg_addr == `ATPG_OFS_MODE);
            if (reg_wr) begin
                if (reg_addr == `ATPG_OFS_DDC0) begin
                    ddc0_test_enable_control_reg <= reg_wdata;
                end else if (reg_addr == `ATPG_OFS_DDC1) begin
                    ddc1_test_enable_control_reg <= reg_wdata;
                end else if (reg_addr == `ATPG_OFS_DDC2) begin
                    ddc2_test_enable_control_reg <= reg_wdata;
                end else if (reg_addr == `ATPG_OFS_FOURTH_DOWNCONVERTER) begin
                    fourth_downconverter_test_enable_control_reg <= reg_wdata;
                end else if (reg_addr == `ATPG_OFS_MODE) begin
                    test_mode_control_reg <= reg_wdata;
                end else if (up_hit) begin
                    user_pattern_reg[up_off[2:0]] <= reg_wdata;
                end
            end
        end
    end

    // register reads
    always @* begin
        rdata_next = `ATPG_REG_RESET;
        if (reg_addr == `ATPG_OFS_DDC0) begin
            rdata_next = ddc0_test_enable_control_reg;
        end else if (reg_addr == `ATPG_OFS_DDC1) begin
            rdata_next = ddc1_test_enable_control_reg;
        end else if (reg_addr == `ATPG_OFS_DDC2) begin
            rdata_next = ddc2_test_enable_control_reg;
        end else if (reg_addr == `ATPG_OFS_FOURTH_DOWNCONVERTER) begin
            rdata_next = fourth_downconverter_test_enable_control_reg;
        end else if (reg_addr == `ATPG_OFS_MODE) begin
            rdata_next = test_mode_control_reg;
        end else if (up_hit) begin
            rdata_next = user_pattern_reg[up_off[2:0]];
        end else if (reg_addr == `ATPG_OFS_STATUS) begin
            rdata_next[`ATPG_F_ST_ACTIVE] = out_test_active;
            rdata_next[`ATPG_F_ST_DONE] = user_done;
            rdata_next[`ATPG_F_ST_BYPASS] = out_fmt_bypass;
        end
    end

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= `ATPG_REG_RESET;
        end else if (ce) begin
            reg_rdata <= reg_rd ? rdata_next : `ATPG_REG_RESET;
        end
    end

    // pseudo_random_sequence generators
    atpg_prbs #(
        .W(`ATPG_PN_LONG_W),
        .TAP(`ATPG_PN_LONG_TAP),
        .SEED(`ATPG_PN_LONG_SEED)
    ) u_pn_long (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .advance(pn_long_step),
        .restart(test_mode_control_reg[`ATPG_F_RST_LONG]),
        .sample(pn_long_sample)
    );

    atpg_prbs #(
        .W(`ATPG_PN_SHORT_W),
        .TAP(`ATPG_PN_SHORT_TAP),
        .SEED(`ATPG_PN_SHORT_SEED)
    ) u_pn_short (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .advance(pn_short_step),
        .restart(test_mode_control_reg[`ATPG_F_RST_SHORT]),
        .sample(pn_short_sample)
    );

    atpg_user_seq u_user (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .ce(ce),
        .advance(user_step),
        .restart(restart_reg),
        .single(test_mode_control_reg[`ATPG_F_SINGLE]),
        .words(user_words),
        .sample(user_sample),
        .done(user_done)
    );

    // pattern select; unlisted codes fall to the off behaviour
    always @* begin
        pattern = `ATPG_CODE_ZERO;
        active = 1'b1;
        bypass = 1'b0;
        case (mode)
            `ATPG_MODE_MID: pattern = `ATPG_CODE_MID;
            `ATPG_MODE_POS: pattern = `ATPG_CODE_POS;
            `ATPG_MODE_NEG: pattern = `ATPG_CODE_NEG;
            `ATPG_MODE_CHK: pattern = phase_reg ? `ATPG_CODE_CHK_B : `ATPG_CODE_CHK_A;
            `ATPG_MODE_PN_LONG: begin
                pattern = pn_long_sample;
                bypass = 1'b1;
            end
            `ATPG_MODE_PN_SHORT: begin
                pattern = pn_short_sample;
                bypass = 1'b1;
            end
            `ATPG_MODE_TOGGLE: pattern = phase_reg ? `ATPG_CODE_ONES : `ATPG_CODE_ZERO;
            `ATPG_MODE_USER: begin
                pattern = user_sample;
                bypass = 1'b1;
            end
            `ATPG_MODE_RAMP: pattern = ramp_reg;
            default: active = 1'b0;
        endcase
    end

    // alternation phase and ramp, restarted whenever the mode is written
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            phase_reg <= 1'b0;
            ramp_reg <= `ATPG_CODE_ZERO;
        end else if (ce) begin
            if (restart_reg) begin
                phase_reg <= 1'b0;
                ramp_reg <= `ATPG_CODE_ZERO;
            end else if (slot) begin
                phase_reg <= ~phase_reg;
                ramp_reg <= ramp_reg + `ATPG_RAMP_STEP;
            end
        end
    end

    // sample path: one output per input slot
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            out_valid <= 1'b0;
            out_a_data <= `ATPG_CODE_ZERO;
            out_b_data <= `ATPG_CODE_ZERO;
            out_test_active <= 1'b0;
            out_fmt_bypass <= 1'b0;
        end else if (ce) begin
            out_valid <= sample_valid;
            out_test_active <= active;
            out_fmt_bypass <= active && bypass;
            if (sample_valid) begin
                out_a_data <= active ? pattern : adc_a_data;
                out_b_data <= active ? pattern : adc_b_data;
            end
        end
    end

    // downconverter injection data; zeroed on each sample slot while no pattern runs so that a
    // stale test word cannot leak into a downconverter enabled later
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ddc_test_i_data <= `ATPG_CODE_ZERO;
            ddc_test_q_data <= `ATPG_CODE_ZERO;
        end else if (ce) begin
            if (sample_valid) begin
                ddc_test_i_data <= active ? pattern : `ATPG_CODE_ZERO;
                ddc_test_q_data <= active ? pattern : `ATPG_CODE_ZERO;
            end
        end
    end

    // downconverter enables, one pair per downconverter;
    // the last one never gets quadrature test data
    wire [`ATPG_DDC_COUNT*`ATPG_DATA_W-1:0] ddc_ctrl;
    wire [`ATPG_DDC_COUNT-1:0] ddc_i_next;
    wire [`ATPG_DDC_COUNT-1:0] ddc_q_next;
    assign ddc_ctrl = {fourth_downconverter_test_enable_control_reg, ddc2_test_enable_control_reg,
        ddc1_test_enable_control_reg, ddc0_test_enable_control_reg};
    generate
        for (g = 0; g < `ATPG_DDC_COUNT; g = g + 1) begin : g_ddc_en
            assign ddc_i_next[g] = ddc_ctrl[g*`ATPG_DATA_W+`ATPG_F_DDC_I];
            if (g == `ATPG_DDC_COUNT - 1) begin : g_no_q
                assign ddc_q_next[g] = 1'b0;
            end else begin : g_q
                assign ddc_q_next[g] = ddc_ctrl[g*`ATPG_DATA_W+`ATPG_F_DDC_Q];
            end
        end
    endgenerate

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ddc_test_i_en <= 4'h0;
            ddc_test_q_en <= 4'h0;
        end else if (ce) begin
            ddc_test_i_en <= ddc_i_next;
            ddc_test_q_en <= ddc_q_next;
        end
    end

endmodule // atpg_top

//--- verilog/atpg_user_seq.v
`timescale 1ns/100ps
`include "atpg_map.vh"

// steps through four user words, wrapping or stopping on zeros
module atpg_user_seq (
    // clock and reset
    input wire clk_sys,
    input wire resetn,
    input wire ce,
    // control
    input wire advance,
    input wire restart,
    input wire single,
    // four 16-bit words, word 0 in the low bits
    input wire [4*`ATPG_UP_WORD_W-1:0] words,
    // sample
    output wire [`ATPG_SAMPLE_W-1:0] sample,
    output wire done
);

    reg [1:0] idx_reg;
    reg done_reg;
    wire [`ATPG_UP_WORD_W-1:0] word_cur;

    assign word_cur = words[{idx_reg, 4'h0} +: `ATPG_UP_WORD_W];
    assign sample = done_reg ? `ATPG_CODE_ZERO :
        word_cur[`ATPG_UP_WORD_W-1:`ATPG_UP_LSB];
    assign done = done_reg;

    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            idx_reg <= 2'h0;
            done_reg <= 1'b0;
        end else if (ce) begin
            if (restart) begin
                idx_reg <= 2'h0;
                done_reg <= 1'b0;
            end else if (advance && !done_reg) begin
                idx_reg <= idx_reg + 2'h1;
                if (single && idx_reg == 2'h3) begin
                    done_reg <= 1'b1;
                end
            end
        end
    end

endmodule // atpg_user_seq
